// *** hw/adcc_consts.vh ***
// constants for the converter control block
`ifndef ADCC_CONSTS_VH
`define ADCC_CONSTS_VH
`define ADCC_AW 8
`define ADCC_DW 32
`define ADCC_OFF_SC1 8'h00
`define ADCC_OFF_SC2 8'h04
`define ADCC_OFF_DATA 8'h08
`define ADCC_OFF_PWR 8'h80
`define ADCC_OFF_TEST 8'h84
`define ADCC_OFF_ITRG 8'h8c
`define ADCC_OFF_IRQ_STAT 8'ha0
`define ADCC_OFF_IRQ_EN 8'ha4
`define ADCC_OFF_IRQ_CLR 8'ha8
`define ADCC_SC1_RST 8'h1f
`define ADCC_SC2_RST 8'h01
`define ADCC_PWR_RST 8'h00
`define ADCC_TEST_RST 8'h00
`define ADCC_ITRG_RST 8'h00
`define ADCC_CH_OFF 5'h1f
`define ADCC_BIT_DONE 7
`define ADCC_BIT_IEN 6
`define ADCC_BIT_CONT 5
`define ADCC_BIT_ACT 7
`define ADCC_BIT_TTYPE 6
`define ADCC_BIT_HPATH 1
`define ADCC_BIT_TNUM 1
`define ADCC_BIT_TEN 0
`define ADCC_BIT_PWR 0
`define ADCC_BIT_ISRC 0
`define ADCC_SC1_WMASK 8'h7f
`define ADCC_SC2_WMASK 8'h7f
`define ADCC_PWR_WMASK 8'h01
`define ADCC_TEST_WMASK 8'h03
`define ADCC_ITRG_WMASK 8'h01
`define ADCC_IRQ_DONE 0
`define ADCC_IRQ_W 2
`define ADCC_IRQ_ABORT 1
`define ADCC_RES_W 12
`define ADCC_CONV_CYCLES 8'd16
`define ADCC_CNT_W 8
`endif

// *** hw/adcc_sync2.v ***
// two-flop synchroniser for pin levels
`timescale 1ns/1ps
module adcc_sync2 (
  input wire clk_sys,
  input wire reset_n,
  input wire din,
  output reg dout
);
  reg meta_reg;
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      meta_reg <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end
endmodule // adcc_sync2

// *** hw/adcc_ctrl.v ***
// converter control: power, self-test, trigger select, sequencing
// Behaviour
// RQ1: power bit 1 switches analog off
// RQ2: pass bit picks second or first self-test
// RQ3: self-test enable selects self-test mode
// RQ4: source bit: 1 PWM count, 0 RTC
// RQ5: continuous mode repeats current channel only
// RQ6: each finish restarts in continuous mode
// RQ7: software configures everything, interrupt enable last
// RQ8: software writes channel with start
// RQ9: interrupt handler reads the result
// RQ10: polling waits done, then reads result
// RQ11: new channel by repeating start write; a write during a conversion only aborts it, with no new start
// RQ12: done flag sets, clears on result read
// RQ13: trigger type 1 hardware, 0 software
// RQ14: path bit 1 NMI pin, 0 internal
// RQ15: software runs two passes per channel, compares
// RQ16: powered off: no start, active clear
// RQ17: reserved bits read zero, ignore writes
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`include "adcc_consts.vh"
module adcc_ctrl (
  input wire clk_sys,
  input wire reset_n,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire nmi_pin,
  input wire rtc_overflow,
  input wire pwm_count_event,
  input wire [11:0] core_result,
  input wire core_done,
  output reg core_start,
  output reg [4:0] core_channel,
  output reg analog_power_off,
  output reg selftest_enable,
  output reg selftest_pass,
  output reg irq
);
  localparam ST_IDLE = 2'b01;
  localparam ST_CONV = 2'b10;

  reg [7:0] sc1_reg;
  reg [7:0] sc2_reg;
  reg [7:0] pwr_reg;
  reg [7:0] test_reg;
  reg [7:0] itrg_reg;
  reg [11:0] data_reg;
  reg done_reg;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [7:0] cnt_reg;
  reg [1:0] irq_stat_reg;
  reg [1:0] irq_en_reg;
  reg trig_prev_reg;
  wire nmi_s;
  wire rtc_s;
  wire pwm_s;
  wire trig_lvl;
  wire trig_edge;
  wire wr_sc1;
  wire rd_data;
  wire ch_valid;
  wire sw_start;
  wire start_go;
  wire finish;
  wire abort;
  wire wr_sc2;
  wire wr_pwr;
  wire wr_test;
  wire wr_itrg;
  wire wr_irq_en;
  wire wr_irq_clr;
  wire conv_active;
  wire [1:0] irq_set;
  wire [1:0] irq_clr_mask;
  wire irq_next;
  reg [31:0] rd_value;

  function [7:0] masked;
    input [31:0] wd;
    input [7:0] msk;
    begin
      masked = wd[7:0] & msk;
    end
  endfunction

  function hit;
    input [7:0] a;
    input [7:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  function [31:0] zext8;
    input [7:0] b;
    begin
      zext8 = {24'h000000, b};
    end
  endfunction

  adcc_sync2 u_sync_nmi (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .din(nmi_pin),
    .dout(nmi_s)
  );
  adcc_sync2 u_sync_rtc (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .din(rtc_overflow),
    .dout(rtc_s)
  );
  adcc_sync2 u_sync_pwm (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .din(pwm_count_event),
    .dout(pwm_s)
  );

  // hardware trigger source selection
  assign trig_lvl = sc2_reg[`ADCC_BIT_HPATH] ? nmi_s : // RQ14
    (itrg_reg[`ADCC_BIT_ISRC] ? pwm_s : rtc_s); // RQ4
  assign trig_edge = trig_lvl & ~trig_prev_reg;
  assign wr_sc1 = reg_wr && hit(reg_addr, `ADCC_OFF_SC1);
  assign wr_sc2 = reg_wr && hit(reg_addr, `ADCC_OFF_SC2);
  assign wr_pwr = reg_wr && hit(reg_addr, `ADCC_OFF_PWR);
  assign wr_test = reg_wr && hit(reg_addr, `ADCC_OFF_TEST);
  assign wr_itrg = reg_wr && hit(reg_addr, `ADCC_OFF_ITRG);
  assign wr_irq_en = reg_wr && hit(reg_addr, `ADCC_OFF_IRQ_EN);
  assign wr_irq_clr = reg_wr && hit(reg_addr, `ADCC_OFF_IRQ_CLR);
  assign rd_data = reg_rd && hit(reg_addr, `ADCC_OFF_DATA);
  assign ch_valid = (sc1_reg[4:0] != `ADCC_CH_OFF);
  // software start: channel write when software triggered
  assign sw_start = wr_sc1 && !sc2_reg[`ADCC_BIT_TTYPE] &&
    (reg_wdata[4:0] != `ADCC_CH_OFF); // RQ13
  assign start_go = !pwr_reg[`ADCC_BIT_PWR] && (state_reg == ST_IDLE) && // RQ16
    (sw_start || (sc2_reg[`ADCC_BIT_TTYPE] && trig_edge && ch_valid)); // RQ13
  assign finish = (state_reg == ST_CONV) && (cnt_reg == 8'h00) && core_done;
  assign abort = (state_reg == ST_CONV) &&
    (pwr_reg[`ADCC_BIT_PWR] || !ch_valid || wr_sc1);
  assign conv_active = (state_reg == ST_CONV) && !pwr_reg[`ADCC_BIT_PWR]; // RQ16
  assign irq_set = {abort, finish && !abort};
  assign irq_clr_mask = wr_irq_clr ? reg_wdata[`ADCC_IRQ_W-1:0] :
    {`ADCC_IRQ_W{1'b0}};
  assign irq_next = (|(irq_stat_reg & irq_en_reg)) ||
    (done_reg && sc1_reg[`ADCC_BIT_IEN]);

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_go) begin
          state_next = ST_CONV;
        end
      end
      ST_CONV: begin
        if (abort) begin
          state_next = ST_IDLE;
        end else if (finish && !sc1_reg[`ADCC_BIT_CONT]) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // sequencing
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 8'h00;
      core_start <= 1'b0;
      core_channel <= `ADCC_CH_OFF;
      trig_prev_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      trig_prev_reg <= trig_lvl;
      core_start <= 1'b0;
      if (start_go) begin
        core_start <= 1'b1;
        core_channel <= sw_start ? reg_wdata[4:0] : sc1_reg[4:0];
        cnt_reg <= `ADCC_CONV_CYCLES;
      end else if (state_reg == ST_CONV && cnt_reg != 8'h00) begin
        cnt_reg <= cnt_reg - 8'h01;
      end
      if (finish && !abort && sc1_reg[`ADCC_BIT_CONT]) begin
        core_start <= 1'b1; // RQ6
        core_channel <= sc1_reg[4:0]; // RQ5
        cnt_reg <= `ADCC_CONV_CYCLES;
      end
    end
  end

  // result capture
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      data_reg <= 12'h000;
    end else if (finish && !abort) begin
      data_reg <= core_result;
    end
  end

  // done flag, set beats read clear
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      done_reg <= 1'b0;
    end else if (finish && !abort) begin
      done_reg <= 1'b1; // RQ12
    end else if (rd_data) begin
      done_reg <= 1'b0; // RQ12
    end
  end

  // control register 1
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      sc1_reg <= `ADCC_SC1_RST;
    end else if (wr_sc1) begin
      sc1_reg <= masked(reg_wdata, `ADCC_SC1_WMASK);
    end
  end

  // control register 2
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      sc2_reg <= `ADCC_SC2_RST;
    end else if (wr_sc2) begin
      sc2_reg <= masked(reg_wdata, `ADCC_SC2_WMASK);
    end
  end

  // power register
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      pwr_reg <= `ADCC_PWR_RST;
    end else if (wr_pwr) begin
      pwr_reg <= masked(reg_wdata, `ADCC_PWR_WMASK); // RQ17
    end
  end

  // self-test register
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      test_reg <= `ADCC_TEST_RST;
    end else if (wr_test) begin
      test_reg <= masked(reg_wdata, `ADCC_TEST_WMASK); // RQ17
    end
  end

  // internal source register
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      itrg_reg <= `ADCC_ITRG_RST;
    end else if (wr_itrg) begin
      itrg_reg <= masked(reg_wdata, `ADCC_ITRG_WMASK); // RQ17
    end
  end

  // interrupt enable register
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      irq_en_reg <= 2'b00;
    end else if (wr_irq_en) begin
      irq_en_reg <= reg_wdata[`ADCC_IRQ_W-1:0];
    end
  end

  // sticky events, set beats clear
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      irq_stat_reg <= 2'b00;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr_mask) | irq_set;
    end
  end

  // power-off output
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      analog_power_off <= 1'b0;
    end else begin
      analog_power_off <= pwr_reg[`ADCC_BIT_PWR]; // RQ1
    end
  end

  // self-test enable output
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      selftest_enable <= 1'b0;
    end else begin
      selftest_enable <= test_reg[`ADCC_BIT_TEN]; // RQ3
    end
  end

  // self-test pass output
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      selftest_pass <= 1'b0;
    end else begin
      selftest_pass <= test_reg[`ADCC_BIT_TNUM]; // RQ2
    end
  end

  // level interrupt output
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_next;
    end
  end

  // read value mux
  always @* begin
    rd_value = 32'h00000000;
    case (reg_addr)
      `ADCC_OFF_SC1: rd_value = zext8({done_reg, sc1_reg[6:0]});
      `ADCC_OFF_SC2: rd_value = zext8({conv_active, sc2_reg[6:0]}); // RQ16
      `ADCC_OFF_DATA: rd_value = {20'h00000, data_reg};
      `ADCC_OFF_PWR: rd_value = zext8(pwr_reg); // RQ17
      `ADCC_OFF_TEST: rd_value = zext8(test_reg); // RQ17
      `ADCC_OFF_ITRG: rd_value = zext8(itrg_reg); // RQ17
      `ADCC_OFF_IRQ_STAT: rd_value = zext8({6'h00, irq_stat_reg});
      `ADCC_OFF_IRQ_EN: rd_value = zext8({6'h00, irq_en_reg});
      default: rd_value = 32'h00000000;
    endcase
  end

  // read port, data one cycle after strobe
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata <= rd_value;
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end
endmodule // adcc_ctrl

// *** verif/adcc_ctrl_properties.sv ***
// port assertions for converter control
`timescale 1ns/1ps
module adcc_ctrl_chk (
  input wire clk_sys,
  input wire reset_n,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire core_start,
  input wire [4:0] core_channel,
  input wire analog_power_off,
  input wire selftest_enable,
  input wire selftest_pass
);
  wire w0 = reg_wr && reg_addr == 8'h00;
  wire rp = reg_rd && reg_addr == 8'h80;
  wire rt = reg_rd && reg_addr == 8'h84;
  wire ri = reg_rd && reg_addr == 8'h8c;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  off_start_a:
    assert property (analog_power_off |-> !core_start) else $error("start while off");
  pwr_read_a:
    assert property ($past(rp) |-> reg_rdata == {31'h0, analog_power_off}) else $error("pwr");
  test_read_a:
    assert property ($past(rt) |-> reg_rdata == {30'h0, selftest_pass, selftest_enable})
      else $error("test");
  itrg_read_a:
    assert property ($past(ri) |-> reg_rdata[31:1] == 31'h0) else $error("itrg");
  read_idle_a:
    assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("idle data");
  start_chan_a:
    assert property (core_start |-> core_channel != 5'h1f) else $error("start off chan");
  chan_hold_a:
    assert property ($changed(core_channel) |-> core_start || $past(w0) || $past(w0, 2))
      else $error("chan moved");
  start_pulse_a:
    assert property (core_start |=> !core_start) else $error("long start");
  cover property (core_start);
  cover property ($past(rp));
  cover property ($changed(core_channel));
endmodule // adcc_ctrl_chk
bind adcc_ctrl adcc_ctrl_chk chk_u (.*);

// *** verif/adcc_ctrl_bench.sv ***
// self-checking bench for converter control
`timescale 1ns/1ps
module adcc_ctrl_bench;
  logic clk_sys = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic core_done = 1'b0, rd_d = 1'b0, core_start, irq;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, v, n_st = 32'h0, q[$];
  logic [11:0] core_result = 12'h0, lr;
  logic [4:0] core_channel;
  logic [2:0] src = 3'h0;
  logic apo, ste, stp;
  int n_errors = 0, total_checks = 0, i, k;
  adcc_ctrl dut_u (.*, .nmi_pin(src[2]), .rtc_overflow(src[0]), .pwm_count_event(src[1]),
    .analog_power_off(apo), .selftest_enable(ste), .selftest_pass(stp));
  initial forever #12.5 clk_sys = ~clk_sys;
  task chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h want %h", $time, s, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    q.push_back(e);
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask
  task wait_st(input logic [31:0] n);
    k = 0;
    while (n_st < n && k < 200) begin
      @(posedge clk_sys);
      k++;
    end
    chk(n_st, n);
  endtask
  task report_and_stop;
    $display("errors %0d checks %0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // read results and start count
  always @(posedge clk_sys) begin
    if (rd_d) chk(reg_rdata, q.pop_front());
    rd_d <= reg_rd;
    if (core_start === 1'b1) n_st <= n_st + 1;
  end
  // analog core stand-in
  always @(posedge clk_sys) if (core_start === 1'b1) begin
    repeat (20) @(posedge clk_sys);
    lr = 12'($urandom);
    core_result <= lr;
    core_done <= 1'b1;
    @(posedge clk_sys);
    core_done <= 1'b0;
  end
  initial begin
    repeat (4000) @(posedge clk_sys);
    n_errors++;
    report_and_stop;
  end
  initial begin
    v = $urandom(32'hdef75a16);
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(8'h80, 32'h0);
    rd(8'h84, 32'h0);
    rd(8'h8c, 32'h0);
    rd(8'h00, 32'h1f);
    rd(8'h40, 32'h0);
    v = $urandom;
    wr(8'h84, v);
    rd(8'h84, v & 32'h3);
    wr(8'h8c, v);
    rd(8'h8c, v & 32'h1);
    wr(8'h84, 32'h0);
    wr(8'h80, 32'hff);
    rd(8'h80, 32'h1);
    chk({31'h0, apo}, 1);
    wr(8'h00, 32'h03);
    rd(8'h04, 32'h01);
    chk(n_st, 0);
    wr(8'h80, 32'h0);
    wr(8'ha4, 32'h1);
    wr(8'h00, 32'h03);
    wait_st(1);
    repeat (25) @(posedge clk_sys);
    chk({31'h0, irq}, 1);
    rd(8'h00, 32'h83);
    rd(8'h08, {20'h0, lr});
    rd(8'h00, 32'h03);
    rd(8'ha0, 32'h1);
    wr(8'ha8, 32'h1);
    repeat (3) @(posedge clk_sys);
    chk({31'h0, irq}, 0);
    v = $urandom % 31;
    i = n_st + 3;
    wr(8'h00, 32'h20 | v);
    wait_st(i);
    chk({27'h0, core_channel}, v);
    wr(8'h00, 32'h1f);
    rd(8'ha0, 32'h3);
    i = n_st;
    repeat (40) @(posedge clk_sys);
    chk(n_st, i);
    // self-test: two passes on two channels
    for (i = 0; i < 4; i++) begin
      wr(8'h84, 32'h1 | ((i & 1) << 1));
      repeat (2) @(posedge clk_sys);
      chk({30'h0, stp, ste}, 32'h1 | ((i & 1) << 1));
      v = n_st;
      wr(8'h00, i >> 1);
      wait_st(v + 1);
      repeat (25) @(posedge clk_sys);
      rd(8'h08, {20'h0, lr});
    end
    wr(8'h84, 32'h0);
    // each trigger source in turn, others must be ignored
    for (i = 0; i < 3; i++) begin
      wr(8'h04, i == 2 ? 32'h43 : 32'h41);
      wr(8'h8c, i);
      if (i == 0) wr(8'h00, 32'h07);
      v = n_st;
      src <= ~(3'h1 << i);
      repeat (8) @(posedge clk_sys);
      chk(n_st, v);
      src <= 3'h0;
      repeat (2) @(posedge clk_sys);
      src <= 3'h1 << i;
      wait_st(v + 1);
      chk({27'h0, core_channel}, 7);
      src <= 3'h0;
      repeat (30) @(posedge clk_sys);
    end
    wr(8'ha4, 32'h0);
    repeat (4) @(posedge clk_sys);
    chk({31'h0, irq}, 0);
    wr(8'h00, 32'h47);
    repeat (3) @(posedge clk_sys);
    chk({31'h0, irq}, 1);
    report_and_stop;
  end
endmodule // adcc_ctrl_bench
